// ---- logic/region_protection_pkg.sv ----
// Package: register map, descriptor fields and fault codes of the region protection block
package region_protection_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam int          OFFSET_W        = 8;
  // Register byte offsets
  localparam logic [7:0]  OFF_REGION0     = 8'h00;
  localparam logic [7:0]  OFF_REGION1     = 8'h04;
  localparam logic [7:0]  OFF_REGION2     = 8'h08;
  localparam logic [7:0]  OFF_REGION3     = 8'h0C;
  localparam logic [7:0]  OFF_PSTATE      = 8'h10;
  localparam logic [7:0]  OFF_SUPERVISOR  = 8'h14;
  localparam logic [7:0]  OFF_CTRL        = 8'h18;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h1C;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h20;
  localparam logic [7:0]  OFF_FAULT_ADDR  = 8'h24;
  localparam logic [7:0]  OFF_FAULT_INFO  = 8'h28;
  // Descriptor fields
  localparam int          BIT_WRITE       = 0;
  localparam int          BIT_EXEC        = 1;
  localparam int          BIT_TOP         = 2;
  localparam int          FLAG_BITS       = 3;
  localparam int          REGION_MSB      = 29;
  localparam int          SEL_LSB         = 30;
  localparam logic [31:0] NULL_DESC       = 32'h0800_0000;
  localparam logic [31:0] DESC_RESET      = NULL_DESC;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
  // Control register bits
  localparam int          CTRL_PROTECTED  = 0;
  localparam int          CTRL_STEP       = 1;
  localparam int          CTRL_WATCH_EN   = 2;
  // Fault codes and status bits
  localparam int          EV_W            = 6;
  localparam int          EV_PERM         = 0;
  localparam int          EV_RANGE        = 1;
  localparam int          EV_WSPACE       = 2;
  localparam int          EV_BREAK        = 3;
  localparam int          EV_STEP         = 4;
  localparam int          EV_WATCH        = 5;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  typedef enum logic [1:0] {
    ACC_READ  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_FETCH = 2'b10
  } access_kind_t;
endpackage : region_protection_pkg

// ---- logic/region_protection_translate.sv ----
// Region protection and logical to physical translation with AXI4-Lite register slave
// Overview of operation
// - Top two logical address bits pick region zero to three.
// - Each region's size, permissions and relocation are applied independently.
// - Only the top or bottom 2^n addresses of a region are legal.
// - Descriptor bit 0 set allows writes to the region.
// - Descriptor bit 1 set allows instruction fetches from the region.
// - Descriptor bit 2 places legal addresses at top (1) or bottom (0).
// - Size 2^n from the lowest set bit above the flags, at n-1.
// - Physical address takes descriptor bits 31..n, logical bits below n.
// - The null descriptor gives a region zero size, nothing legal.
// - Logical bits n..29 must be all ones (top) or all zeros (bottom).
// - One 32-bit descriptor register per region.
// - A state-save pointer is held for traps of the protected process.
// - The supervisor workspace descriptor is held for returning control.
// - Breakpoint, single step and watchpoint writes return to the supervisor.
// - Reads always allowed; write or fetch without permission traps.
// - A non-writable workspace pointer location gives a restartable trap.
`timescale 1ns/100ps
module region_protection_translate #(
  parameter logic [31:0] WATCH_BASE_DEFAULT = 32'h0000_0000,
  parameter logic [31:0] WATCH_MASK_DEFAULT = 32'hFFFF_FFFF
) (
  input  wire logic        clk_sys_i,          // Processor clock, 25 MHz
  input  wire logic        nrst_i,             // Asynchronous reset, active low
  // Core access check
  input  wire logic        acc_valid_i,        // Logical access presented this cycle
  input  wire logic [1:0]  acc_kind_i,         // 00 read, 01 write, 10 fetch
  input  wire logic [31:0] acc_addr_i,         // Logical address
  input  wire logic [31:0] workspace_pointer_i, // Current workspace pointer
  input  wire logic        workspace_pointer_check_i,       // Workspace pointer just changed
  input  wire logic        breakpoint_jump_i,  // Breakpoint jump executed
  input  wire logic        step_done_i,        // One instruction completed
  output logic [31:0]      phys_addr_o,        // Translated physical address
  output logic             fault_o,            // Access violation, same cycle
  output logic             fault_perm_o,       // Permission fault
  output logic             fault_range_o,      // Out of range fault
  output logic             fault_wspace_o,     // Restartable workspace fault
  output logic             to_supervisor_o,    // Return control to supervisor
  output logic [31:0]      pstate_ptr_o,       // State save pointer
  output logic [31:0]      supervisor_desc_o,  // Supervisor workspace descriptor
  output logic             irq_o,              // Level interrupt
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,       // Write address
  input  wire logic        s_axi_awvalid,      // Write address valid
  output logic             s_axi_awready,      // Write address ready
  input  wire logic [31:0] s_axi_wdata,        // Write data
  input  wire logic [3:0]  s_axi_wstrb,        // Write strobes
  input  wire logic        s_axi_wvalid,       // Write data valid
  output logic             s_axi_wready,       // Write data ready
  output logic [1:0]       s_axi_bresp,        // Write response
  output logic             s_axi_bvalid,       // Write response valid
  input  wire logic        s_axi_bready,       // Write response ready
  input  wire logic [7:0]  s_axi_araddr,       // Read address
  input  wire logic        s_axi_arvalid,      // Read address valid
  output logic             s_axi_arready,      // Read address ready
  output logic [31:0]      s_axi_rdata,        // Read data
  output logic [1:0]       s_axi_rresp,        // Read response
  output logic             s_axi_rvalid,       // Read data valid
  input  wire logic        s_axi_rready        // Read response ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] desc_r [4];
  logic [31:0] desc_nxt [4];
  logic [31:0] pstate_r, pstate_nxt;
  logic [31:0] super_r, super_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [31:0] watch_base_r, watch_mask_r;
  logic [5:0]  sts_r, sts_nxt;
  logic [5:0]  mask_r, mask_nxt;
  logic [31:0] faddr_r, faddr_nxt;
  logic [31:0] finfo_r, finfo_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        aw_held_r, aw_held_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        w_held_r, w_held_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Per region decode
  logic [3:0]  legal_top, legal_bot, legal_w, wsp_ok;
  logic [31:0] phys_r0 [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_region
      logic [31:0] d;
      logic [31:0] keep_mask;   // Ones on logical bits kept (below n)
      logic [31:0] chk_mask;    // Ones on bits n..29
      logic        is_null;
      assign d = desc_r[g];
      assign is_null = (d == region_protection_pkg::NULL_DESC);
      always_comb begin
        logic found;
        found = 1'b0;
        keep_mask = '0;
        for (int b = region_protection_pkg::FLAG_BITS; b < region_protection_pkg::SEL_LSB; b++) begin
          if (!found) begin
            keep_mask[b] = 1'b1;
            if (d[b]) begin
              found = 1'b1;
            end
          end
        end
        keep_mask[region_protection_pkg::FLAG_BITS-1:0] = '1;
        chk_mask = ~keep_mask;
        chk_mask[31:region_protection_pkg::SEL_LSB] = 2'b00;
      end
      // Bits n..29 all ones when top, all zeros when bottom
      assign legal_top[g] = ((acc_addr_i & chk_mask) == chk_mask);
      assign legal_bot[g] = ((acc_addr_i & chk_mask) == '0);
      assign legal_w[g]   = !is_null &&
                            (d[region_protection_pkg::BIT_TOP] ? legal_top[g] : legal_bot[g]);
      // Workspace location must fall inside the region and allow writes
      assign wsp_ok[g]    = !is_null && d[region_protection_pkg::BIT_WRITE] &&
                            (d[region_protection_pkg::BIT_TOP]
                              ? ((workspace_pointer_i & chk_mask) == chk_mask)
                              : ((workspace_pointer_i & chk_mask) == '0));
      assign phys_r0[g]   = (d & ~keep_mask) | (acc_addr_i & keep_mask);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Access check
  logic [1:0]  sel, wsel;
  logic [31:0] cur_desc;
  logic        prot, in_range, perm_bad, wsp_bad, watch_hit, is_write, is_fetch;

  always_comb begin
    sel      = acc_addr_i[31:region_protection_pkg::SEL_LSB];
    wsel     = workspace_pointer_i[31:region_protection_pkg::SEL_LSB];
    cur_desc = desc_r[sel];
    prot     = ctrl_r[region_protection_pkg::CTRL_PROTECTED];
    is_write = (acc_kind_i == region_protection_pkg::ACC_WRITE);
    is_fetch = (acc_kind_i == region_protection_pkg::ACC_FETCH);
    in_range = legal_w[sel];
    perm_bad = (is_write && !cur_desc[region_protection_pkg::BIT_WRITE]) ||
               (is_fetch && !cur_desc[region_protection_pkg::BIT_EXEC]);
    wsp_bad  = prot && workspace_pointer_check_i && !wsp_ok[wsel];
    watch_hit = ctrl_r[region_protection_pkg::CTRL_WATCH_EN] && acc_valid_i && is_write &&
                ((acc_addr_i & watch_mask_r) == (watch_base_r & watch_mask_r));
  end

  always_comb begin
    fault_range_o  = prot && acc_valid_i && !in_range;
    fault_perm_o   = prot && acc_valid_i && in_range && perm_bad;
    fault_wspace_o = wsp_bad;
    fault_o        = fault_range_o || fault_perm_o || fault_wspace_o;
    to_supervisor_o = prot && (fault_o || breakpoint_jump_i ||
                      (ctrl_r[region_protection_pkg::CTRL_STEP] && step_done_i) ||
                      watch_hit);
    phys_addr_o    = prot ? phys_r0[sel] : acc_addr_i;
  end

  assign pstate_ptr_o      = pstate_r;
  assign supervisor_desc_o = super_r;
  assign irq_o             = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       wr_go, rd_go;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [5:0]  ev;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_held_nxt = aw_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    w_held_nxt  = w_held_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_held_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      w_held_nxt = 1'b1;
    end
    wr_go = aw_held_r && w_held_r && !bvalid_r;
    wa    = awaddr_r;
    wd    = wdata_r;
    ws    = wstrb_r;
    if (wr_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
    end
  end

  always_comb begin
    ev = '0;
    ev[region_protection_pkg::EV_PERM]   = fault_perm_o;
    ev[region_protection_pkg::EV_RANGE]  = fault_range_o;
    ev[region_protection_pkg::EV_WSPACE] = fault_wspace_o;
    ev[region_protection_pkg::EV_BREAK]  = prot && breakpoint_jump_i;
    ev[region_protection_pkg::EV_STEP]   = prot && ctrl_r[region_protection_pkg::CTRL_STEP] && step_done_i;
    ev[region_protection_pkg::EV_WATCH]  = prot && watch_hit;
    for (int i = 0; i < 4; i++) begin
      desc_nxt[i] = desc_r[i];
    end
    pstate_nxt = pstate_r;
    super_nxt  = super_r;
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    sts_nxt    = sts_r;
    faddr_nxt  = faddr_r;
    finfo_nxt  = finfo_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt  = bresp_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = region_protection_pkg::RESP_OKAY;
      unique case (wa)
        region_protection_pkg::OFF_REGION0:    desc_nxt[0] = merge(desc_r[0], wd, ws);
        region_protection_pkg::OFF_REGION1:    desc_nxt[1] = merge(desc_r[1], wd, ws);
        region_protection_pkg::OFF_REGION2:    desc_nxt[2] = merge(desc_r[2], wd, ws);
        region_protection_pkg::OFF_REGION3:    desc_nxt[3] = merge(desc_r[3], wd, ws);
        region_protection_pkg::OFF_PSTATE:     pstate_nxt  = merge(pstate_r, wd, ws);
        region_protection_pkg::OFF_SUPERVISOR: super_nxt   = merge(super_r, wd, ws);
        region_protection_pkg::OFF_CTRL:       ctrl_nxt    = ws[0] ? wd[2:0] : ctrl_r;
        region_protection_pkg::OFF_IRQ_STATUS: sts_nxt     = ws[0] ? (sts_r & ~wd[5:0]) : sts_r;
        region_protection_pkg::OFF_IRQ_MASK:   mask_nxt    = ws[0] ? wd[5:0] : mask_r;
        region_protection_pkg::OFF_FAULT_ADDR,
        region_protection_pkg::OFF_FAULT_INFO: ;
        default:                               bresp_nxt   = region_protection_pkg::RESP_SLVERR;
      endcase
    end
    // Set wins over a simultaneous clear
    sts_nxt = sts_nxt | ev;
    if (|ev) begin
      faddr_nxt = fault_wspace_o ? workspace_pointer_i : acc_addr_i;
      finfo_nxt = {24'h00_0000, acc_kind_i, ev};
    end
  end

  always_comb begin
    rd_go      = s_axi_arvalid && s_axi_arready;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = region_protection_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        region_protection_pkg::OFF_REGION0:    rdata_nxt = desc_r[0];
        region_protection_pkg::OFF_REGION1:    rdata_nxt = desc_r[1];
        region_protection_pkg::OFF_REGION2:    rdata_nxt = desc_r[2];
        region_protection_pkg::OFF_REGION3:    rdata_nxt = desc_r[3];
        region_protection_pkg::OFF_PSTATE:     rdata_nxt = pstate_r;
        region_protection_pkg::OFF_SUPERVISOR: rdata_nxt = super_r;
        region_protection_pkg::OFF_CTRL:       rdata_nxt = {29'h0, ctrl_r};
        region_protection_pkg::OFF_IRQ_STATUS: rdata_nxt = {26'h0, sts_r};
        region_protection_pkg::OFF_IRQ_MASK:   rdata_nxt = {26'h0, mask_r};
        region_protection_pkg::OFF_FAULT_ADDR: rdata_nxt = faddr_r;
        region_protection_pkg::OFF_FAULT_INFO: rdata_nxt = finfo_r;
        default: begin
          rdata_nxt = region_protection_pkg::WORD_RESET;
          rresp_nxt = region_protection_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        desc_r[i] <= region_protection_pkg::DESC_RESET;
      end
      pstate_r     <= region_protection_pkg::WORD_RESET;
      super_r      <= region_protection_pkg::WORD_RESET;
      ctrl_r       <= 3'b000;
      watch_base_r <= WATCH_BASE_DEFAULT;
      watch_mask_r <= WATCH_MASK_DEFAULT;
      sts_r        <= '0;
      mask_r       <= '0;
      faddr_r      <= region_protection_pkg::WORD_RESET;
      finfo_r      <= region_protection_pkg::WORD_RESET;
      awaddr_r     <= '0;
      aw_held_r    <= 1'b0;
      wdata_r      <= region_protection_pkg::WORD_RESET;
      wstrb_r      <= '0;
      w_held_r     <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= region_protection_pkg::RESP_OKAY;
      rvalid_r     <= 1'b0;
      rresp_r      <= region_protection_pkg::RESP_OKAY;
      rdata_r      <= region_protection_pkg::WORD_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        desc_r[i] <= desc_nxt[i];
      end
      pstate_r     <= pstate_nxt;
      super_r      <= super_nxt;
      ctrl_r       <= ctrl_nxt;
      watch_base_r <= watch_base_r;
      watch_mask_r <= watch_mask_r;
      sts_r        <= sts_nxt;
      mask_r       <= mask_nxt;
      faddr_r      <= faddr_nxt;
      finfo_r      <= finfo_nxt;
      awaddr_r     <= awaddr_nxt;
      aw_held_r    <= aw_held_nxt;
      wdata_r      <= wdata_nxt;
      wstrb_r      <= wstrb_nxt;
      w_held_r     <= w_held_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rresp_r      <= rresp_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

endmodule : region_protection_translate

// ---- dv/region_protection_translate_properties.sv ----
// Concurrent checks on the access check and register bus ports
`timescale 1ns/100ps
module region_protection_translate_properties (
  input wire logic        clk_sys_i,       // Clock
  input wire logic        nrst_i,          // Reset, active low
  input wire logic        acc_valid_i,     // Access presented
  input wire logic [1:0]  acc_kind_i,      // Access kind
  input wire logic [31:0] acc_addr_i,      // Logical address
  input wire logic [31:0] phys_addr_o,     // Physical address
  input wire logic        fault_o,         // Any fault
  input wire logic        fault_perm_o,    // Permission fault
  input wire logic        fault_range_o,   // Range fault
  input wire logic        to_supervisor_o, // Back to supervisor
  input wire logic        s_axi_awvalid,   // Write address valid
  input wire logic        s_axi_awready,   // Write address ready
  input wire logic        s_axi_wvalid,    // Write data valid
  input wire logic        s_axi_wready,    // Write data ready
  input wire logic        s_axi_bvalid,    // Write response valid
  input wire logic        s_axi_bready,    // Write response ready
  input wire logic        s_axi_arvalid,   // Read address valid
  input wire logic        s_axi_arready,   // Read address ready
  input wire logic        s_axi_rvalid,    // Read data valid
  input wire logic        s_axi_rready,    // Read data ready
  input wire logic [31:0] s_axi_rdata      // Read data
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_fault_kinds: assert property ((fault_perm_o || fault_range_o) |-> fault_o && to_supervisor_o)
    else $error("fault kind without fault or supervisor return");
  a_read_allowed: assert property (acc_valid_i && acc_kind_i == 2'b00 |-> !fault_perm_o)
    else $error("permission fault on a read");
  a_range_first: assert property (fault_range_o |-> !fault_perm_o)
    else $error("range and permission fault together");
  a_low_bits_kept: assert property (!fault_o |-> phys_addr_o[7:0] == acc_addr_i[7:0])
    else $error("low address bits changed by translation");
  a_idle_quiet: assert property (!acc_valid_i |-> !fault_perm_o && !fault_range_o)
    else $error("access fault without an access");
  a_write_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule : region_protection_translate_properties
bind region_protection_translate region_protection_translate_properties u_props (.*);

// ---- dv/core_access_model.sv ----
// Model of the processor core presenting logical accesses
`timescale 1ns/100ps
module core_access_model (
  input  wire logic  clk_i,        // Processor clock
  output logic       acc_valid_o,  // Access presented
  output logic [1:0] acc_kind_o,   // Access kind
  output logic [31:0] acc_addr_o,  // Logical address
  output logic [31:0] workspace_pointer_o,      // Workspace pointer
  output logic       workspace_pointer_check_o, // Workspace pointer changed
  output logic       brk_o,        // Breakpoint jump
  output logic       step_o        // Instruction completed
);
  initial begin
    acc_valid_o = 1'b0;
    acc_kind_o = 2'h0;
    acc_addr_o = 32'h0;
    workspace_pointer_o = 32'h0;
    workspace_pointer_check_o = 1'b0;
    brk_o = 1'b0;
    step_o = 1'b0;
  end
  // One access for one cycle after gap plus one idle cycles; released lines show a changed pattern
  task automatic issue(input logic [1:0] k, input logic [31:0] a, w, input logic c, b, s, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_kind_o <= k;
    acc_addr_o <= a;
    workspace_pointer_o <= w;
    workspace_pointer_check_o <= c;
    brk_o <= b;
    step_o <= s;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o <= ~a;
    workspace_pointer_o <= ~w;
    workspace_pointer_check_o <= 1'b0;
    brk_o <= 1'b0;
    step_o <= 1'b0;
  endtask : issue
endmodule : core_access_model

// ---- dv/region_protection_translate_tb.sv ----
// Self-checking bench for the region protection and translation block
`timescale 1ns/100ps
module region_protection_translate_tb;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        acc_valid, wchk, brk, step, f, fp, fr, fw, sup, irq;
  logic [1:0]  kind, bresp, rresp;
  logic [31:0] addr, workspace_pointer, phys, pptr, sdesc, rdata, t, a;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, prot = 0;
  logic [35:0] rsp_q[$], acc_q[$], e;
  logic [31:0] d[4];
  logic [31:0] seed = 32'h90B1E882;
  int          nn[4];
  int          mismatches = 0, checked = 0, cycles = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  region_protection_translate dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .acc_valid_i(acc_valid),
    .acc_kind_i(kind), .acc_addr_i(addr), .workspace_pointer_i(workspace_pointer), .workspace_pointer_check_i(wchk),
    .breakpoint_jump_i(brk), .step_done_i(step), .phys_addr_o(phys), .fault_o(f), .fault_perm_o(fp),
    .fault_range_o(fr), .fault_wspace_o(fw), .to_supervisor_o(sup), .pstate_ptr_o(pptr),
    .supervisor_desc_o(sdesc), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  core_access_model u_core (.clk_i(clk_sys_i), .acc_valid_o(acc_valid), .acc_kind_o(kind),
    .acc_addr_o(addr), .workspace_pointer_o(workspace_pointer), .workspace_pointer_check_o(wchk), .brk_o(brk), .step_o(step));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : rnd
  task automatic check(input string nm, input logic [35:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Response phase: ready raised one cycle late, held until the answer
  task automatic resp(input logic is_rd);
    @(posedge clk_sys_i);
    if (is_rd) rready <= 1'b1;
    else bready <= 1'b1;
    do @(posedge clk_sys_i); while (!(is_rd ? rvalid : bvalid));
    if (is_rd) rready <= 1'b0;
    else bready <= 1'b0;
  endtask : resp
  task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    rsp_q.push_back({2'b00, er, 32'h0});
    @(posedge clk_sys_i);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk_sys_i);
      if (aw_p && awready) awvalid <= 1'b0;
      if (w_p && wready) wvalid <= 1'b0;
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
    end
    resp(1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [35:0] ex);
    rsp_q.push_back(ex);
    @(posedge clk_sys_i);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge clk_sys_i); while (!arready);
    arvalid <= 1'b0;
    resp(1'b1);
  endtask : rd
  // Expected {range, perm, phys} of one access under the current descriptors
  function automatic logic [33:0] chk(logic [1:0] k, logic [31:0] la);
    logic [31:0] dd, m;
    logic rg;
    int n;
    dd = d[la[31:30]];
    n = 8;
    while (n < 30 && !dd[n-1]) n++;
    m = (32'h1 << n) - 32'h1;
    rg = (dd == region_protection_pkg::NULL_DESC);
    for (int i = n; i < 30; i++) rg = rg | (la[i] != dd[2]);
    return {rg, !rg && ((k == 2'b01 && !dd[0]) || (k == 2'b10 && !dd[1])), (dd & ~m) | (la & m)};
  endfunction : chk
  task automatic acc(input logic [1:0] k, input logic [31:0] la, w, input logic c, b, s);
    logic [33:0] r, q;
    r = chk(k, la);
    q = chk(2'b01, w);
    if (!prot) acc_q.push_back({4'h0, la});
    // Watch region of the default parameters is the single address zero
    else acc_q.push_back({c && q[33:32] != 2'b00, b || s || (k == 2'b01 && la == 32'h0) ||
                          (c && q[33:32] != 2'b00) || r[33:32] != 2'b00,
                          r[33:32], r[33:32] != 2'b00 ? 32'h0 : r[31:0]});
    u_core.issue(k, la, w, c, b, s, int'(seed[1:0]));
  endtask : acc
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      conclude();
    end
    if (bvalid && bready) check("write response", {2'b00, bresp, 32'h0}, rsp_q.pop_front());
    if (rvalid && rready) check("read data", {2'b00, rresp, rdata}, rsp_q.pop_front());
    if (acc_valid) begin
      e = acc_q.pop_front();
      check("access", {fw, sup, fr, fp, e[33:32] != 2'b00 ? 32'h0 : phys}, e);
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), {4'h0, i < 4 ? region_protection_pkg::NULL_DESC : region_protection_pkg::WORD_RESET});
    rd(8'h40, {4'h2, 32'h0});
    wr(8'h40, 32'h1, 2'b10);
    acc(2'b01, rnd(), rnd(), 1'b1, 1'b1, 1'b1);
    t = rnd();
    wr(8'h10, t, 2'b00);
    check("state pointer", {4'h0, pptr}, {4'h0, t});
    wr(8'h14, ~t, 2'b00);
    check("supervisor", {4'h0, sdesc}, {4'h0, ~t});
    wr(8'h18, 32'h7, 2'b00);
    prot = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        t = rnd();
        nn[r] = 8 + int'(t[4:0]) % 23;
        d[r] = (t & ~((32'h1 << nn[r]) - 32'h1)) | (32'h1 << (nn[r] - 1)) | {29'h0, t[7:5]};
        if (p == 1 && r == 3) d[r] = region_protection_pkg::NULL_DESC;
        wr(8'(4 * r), d[r], 2'b00);
        rd(8'(4 * r), {4'h0, d[r]});
      end
      for (int j = 0; j < 60; j++) begin
        t = rnd();
        a = rnd();
        for (int i = 8; i < 30; i++) if (t[1:0] != 2'b00 && i >= nn[a[31:30]]) a[i] = d[a[31:30]][2];
        acc(t[3:2] == 2'b11 ? 2'b00 : t[3:2], a, t[8] ? a : rnd(), t[4], t[5] & t[6], t[7]);
      end
    end
    acc(2'b01, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    check("irq masked", {35'h0, irq}, 36'h0);
    wr(8'h20, 32'h3F, 2'b00);
    check("irq raised", {35'h0, irq}, 36'h1);
    wr(8'h1C, 32'h3F, 2'b00);
    check("irq cleared", {35'h0, irq}, 36'h0);
    rd(8'h1C, {4'h0, 32'h0});
    conclude();
  end
endmodule : region_protection_translate_tb
